// file: core/wds_pkg.sv
package wds_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int          RST_HOLD_US   = 7400;
    localparam int          SS_BOOST_US   = 1900;
    localparam int          SS_BUCK_US    = 2500;
    localparam int          RST_HOLD_CYC  = RST_HOLD_US * CYC_PER_US;
    localparam int          SS_BOOST_CYC  = SS_BOOST_US * CYC_PER_US;
    localparam int          SS_BUCK_CYC   = SS_BUCK_US * CYC_PER_US;
    localparam int          CNT_W         = 17;

    localparam int          SYNC_MIN_HZ   = 1_800_000;
    localparam int          SYNC_MAX_HZ   = 2_600_000;
    localparam int          SYNC_OUT_HZ   = 2_200_000;
    localparam int          SPREAD_PCT    = 3;
    localparam logic [3:0]  SYNC_MIN_CYC  = 4'((CLK_HZ + SYNC_MAX_HZ - 1) / SYNC_MAX_HZ);
    localparam logic [3:0]  SYNC_MAX_CYC  = 4'(CLK_HZ / SYNC_MIN_HZ);
    localparam logic [31:0] NCO_STEP      = 32'((64'(SYNC_OUT_HZ) << 32) / CLK_HZ);
    localparam logic [31:0] NCO_SPREAD    = 32'((64'(NCO_STEP) * SPREAD_PCT) / 100);
    localparam logic [31:0] NCO_UNIT      = NCO_SPREAD / 32'h0000_0080;
    localparam logic [31:0] NCO_LOW       = NCO_STEP - NCO_SPREAD;
    localparam logic [15:0] LFSR_SEED     = 16'hACE1;

    localparam logic [31:0] CFG_ADDR      = 32'h0000_0000;
    localparam logic [31:0] STAT_ADDR     = 32'h0000_0004;
    localparam logic [31:0] TICK_ADDR     = 32'h0000_0008;
    localparam logic [6:0]  CFG_RST       = 7'h00;
    localparam int          CFG_WATCH_LSB = 0;
    localparam int          CFG_EXT_BIT   = 3;
    localparam int          CFG_TPM_BIT   = 4;
    localparam int          CFG_RATIO_BIT = 5;
    localparam int          CFG_SYNC_BIT  = 6;

    localparam logic [15:0] RATIO_LO      = 16'h0008;
    localparam logic [15:0] RATIO_HI      = 16'h0010;
    localparam logic [15:0] TPM_LO        = 16'h0010;
    localparam logic [15:0] TPM_HI        = 16'h0040;
    localparam logic [15:0] EXT_LO        = 16'h0040;
    localparam logic [15:0] EXT_HI        = 16'h0080;

    typedef enum logic [1:0] {WD_IDLE, WD_FIRST, WD_MASK, WD_UPDATE} wds_wd_state_t;
    typedef enum logic [1:0] {CH_OFF, CH_RAMP, CH_HOLD, CH_ON} wds_ch_state_t;
endpackage

// file: core/wds_chan.sv
`timescale 1ns/1ns
module wds_chan
    import wds_pkg::*;
#(
    parameter int SS_CYC   = SS_BUCK_CYC,
    parameter int HOLD_CYC = RST_HOLD_CYC
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic in_window,
    input  wire logic rst_pin_i,
    input  wire logic sense_open,
    input  wire logic shutdown,
    input  wire logic wd_trip,
    output logic      conv_on,
    output logic      ramp,
    output logic      rst_oe
);
    wds_ch_state_t    st_ff;
    wds_ch_state_t    nxt_st;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb
    begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff + 1'b1;
        if (!en || shutdown || sense_open)
        begin
            nxt_st  = CH_OFF;
            nxt_cnt = '0;
        end
        else
        begin
            case (st_ff)
                CH_OFF:
                begin
                    nxt_cnt = '0;
                    // pin reads high while pulled low: shorted, no start
                    if (!rst_pin_i)
                        nxt_st = CH_RAMP;
                end
                CH_RAMP:
                begin
                    if (cnt_ff == CNT_W'(SS_CYC - 1))
                    begin
                        nxt_st  = CH_HOLD;
                        nxt_cnt = '0;
                    end
                end
                CH_HOLD:
                begin
                    if (!in_window || wd_trip)
                        nxt_cnt = '0;
                    else if (cnt_ff == CNT_W'(HOLD_CYC - 1))
                        nxt_st = CH_ON;
                end
                default:
                begin
                    nxt_cnt = '0;
                    if (!in_window || wd_trip)
                        nxt_st = CH_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff   <= CH_OFF;
            cnt_ff  <= '0;
            conv_on <= 1'b0;
            ramp    <= 1'b0;
            rst_oe  <= 1'b1;
        end
        else
        begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            conv_on <= nxt_st != CH_OFF;
            ramp    <= nxt_st == CH_RAMP;
            rst_oe  <= nxt_st != CH_ON;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    hold_release_a: assert property ($fell(rst_oe) |->
        $past(st_ff) == CH_HOLD && $past(cnt_ff) == CNT_W'(HOLD_CYC - 1))
        else $error("reset released before hold time");
    short_inhibit_a: assert property ((st_ff == CH_OFF && rst_pin_i) |=>
        st_ff == CH_OFF && !conv_on)
        else $error("start despite shorted reset pin");
    sense_open_a: assert property (sense_open |=> !conv_on)
        else $error("channel runs with open sense");
endmodule // wds_chan

// file: core/wds_top.sv
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - watchdog expiry asserts resets of watched channels
// - watchdog runs only with watched channels enabled
// - update window is mask times ratio plus one
// - mask window is 16 or 64 ticks
// - first window is mask times ratio plus 64 or 128
// - three bits pick which channels are watched
// - capacitor threshold discharges and advances the counter
// - refresh ignored during mask window
// - watchdog start uses extended first window, no mask
// - each channel reset low when output out-of-window
// - reset held 7.4ms after output reaches regulation
// - shorted-high reset pin blocks channel start
// - enables independent; rising enable starts soft-start
// - soft-start 1.9ms boost, 2.5ms each buck
// - sync input high forces PWM, low allows skip
// - external sync clock between 1.8 and 2.6MHz
// - sync output mode drives 2.2MHz, forces PWM
// - internal clock spread plus-minus 3 percent, pseudorandom
// - power-good only with an enable; else driven low
// - over-temperature stops bias and converters, auto restart
// - open sense connection turns channel off
module wds_top
    import wds_pkg::*;
#(
    parameter int RST_HOLD_CYC_P = RST_HOLD_CYC,
    parameter int SS_BOOST_CYC_P = SS_BOOST_CYC,
    parameter int SS_BUCK_CYC_P  = SS_BUCK_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        boost_channel_enable,
    input  wire logic        buck_a_channel_enable,
    input  wire logic        buck_b_channel_enable,
    input  wire logic        boost_in_window,
    input  wire logic        buck_a_in_window,
    input  wire logic        buck_b_in_window,
    input  wire logic        boost_sense_open,
    input  wire logic        buck_a_sense_open,
    input  wire logic        buck_b_sense_open,
    input  wire logic        boost_channel_reset_n_i,
    output logic             boost_channel_reset_n_o,
    output logic             boost_channel_reset_n_oe,
    input  wire logic        buck_a_reset_n_i,
    output logic             buck_a_reset_n_o,
    output logic             buck_a_reset_n_oe,
    input  wire logic        buck_b_reset_n_i,
    output logic             buck_b_reset_n_o,
    output logic             buck_b_reset_n_oe,
    output logic             boost_output_on,
    output logic             buck_a_output_on,
    output logic             buck_b_output_on,
    output logic             boost_soft_start,
    output logic             buck_a_soft_start,
    output logic             buck_b_soft_start,
    input  wire logic        watchdog_refresh_in,
    input  wire logic        watchdog_tick_capacitor_i,
    output logic             watchdog_tick_capacitor_o,
    output logic             watchdog_tick_capacitor_oe,
    input  wire logic        input_supply_ok,
    output logic             input_power_good_n_o,
    output logic             input_power_good_n_oe,
    input  wire logic        over_temp,
    input  wire logic        temp_cooled,
    output logic             bias_enable,
    input  wire logic        sync_pin_i,
    output logic             sync_pin_o,
    output logic             sync_pin_oe,
    output logic             forced_fixed_frequency_mode
);
    logic [2:0]    en;
    logic [2:0]    win;
    logic [2:0]    sopen;
    logic [2:0]    rpin;
    logic [2:0]    on;
    logic [2:0]    ramp;
    logic [2:0]    rst_oe;
    logic [2:0]    watch;
    logic [6:0]    cfg_ff;
    logic          wr_pend_ff;
    logic [31:0]   wr_addr_ff;
    logic          take;
    logic [31:0]   nxt_rdata;
    logic          od_low_ff;
    logic          shut_ff;
    logic          nxt_shut;
    logic          tick;
    logic          wd_run;
    wds_wd_state_t wd_st_ff;
    logic [15:0]   wd_cnt_ff;
    logic [15:0]   cnt_inc;
    logic [15:0]   mask_len;
    logic [15:0]   ratio;
    logic [15:0]   ext;
    logic [15:0]   lim;
    logic          in_upd;
    logic          expire;
    logic          trip_ff;
    logic          ref_q_ff;
    logic          armed_ff;
    logic          ref_done;
    logic          sync_q_ff;
    logic          srise;
    logic [3:0]    per_ff;
    logic          locked_ff;
    logic [31:0]   acc_ff;
    logic [32:0]   acc_sum;
    logic [31:0]   step;
    logic [15:0]   lfsr_ff;

    function automatic logic [15:0] win_len(input logic [15:0] m, input logic [15:0] k);
        logic [31:0] p;
        p = 32'(m) * 32'(k);
        return p[15:0];
    endfunction

    assign en    = {buck_b_channel_enable, buck_a_channel_enable, boost_channel_enable};
    assign win   = {buck_b_in_window, buck_a_in_window, boost_in_window};
    assign sopen = {buck_b_sense_open, buck_a_sense_open, boost_sense_open};
    assign rpin  = {buck_b_reset_n_i, buck_a_reset_n_i, boost_channel_reset_n_i};
    assign watch = cfg_ff[CFG_WATCH_LSB +: 3];

    // register bus: zero wait states, always OKAY
    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        if (haddr == CFG_ADDR)
            nxt_rdata = {25'h000_0000, cfg_ff};
        else if (haddr == STAT_ADDR)
            nxt_rdata = {20'h0_0000, wd_st_ff, locked_ff, forced_fixed_frequency_mode,
                         shut_ff, on, rst_oe, armed_ff};
        else if (haddr == TICK_ADDR)
            nxt_rdata = {16'h0000, wd_cnt_ff};
        else
            nxt_rdata = 32'h0000_0000;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h0000_0000;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
        else
        begin
            wr_pend_ff <= take && hwrite;
            wr_addr_ff <= haddr;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (take && !hwrite)
                hrdata <= nxt_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_ff <= CFG_RST;
        else if (wr_pend_ff && wr_addr_ff == CFG_ADDR)
            cfg_ff <= hwdata[6:0];
    end

    // open-drain data is always low; only the enables move
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            od_low_ff <= 1'b0;
        else
            od_low_ff <= 1'b0;
    end

    assign boost_channel_reset_n_o   = od_low_ff;
    assign buck_a_reset_n_o          = od_low_ff;
    assign buck_b_reset_n_o          = od_low_ff;
    assign watchdog_tick_capacitor_o = od_low_ff;
    assign input_power_good_n_o      = od_low_ff;

    // thermal shutdown, restart only after cooling hysteresis
    always_comb
    begin
        nxt_shut = shut_ff;
        if (over_temp)
            nxt_shut = 1'b1;
        else if (temp_cooled)
            nxt_shut = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shut_ff     <= 1'b0;
            bias_enable <= 1'b0;
        end
        else
        begin
            shut_ff     <= nxt_shut;
            bias_enable <= !nxt_shut;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            input_power_good_n_oe <= 1'b1;
        else
            input_power_good_n_oe <= !(|en) || !input_supply_ok;
    end

    // a tick is the threshold seen while not already discharging
    assign tick = watchdog_tick_capacitor_i && !watchdog_tick_capacitor_oe;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            watchdog_tick_capacitor_oe <= 1'b0;
        else
            watchdog_tick_capacitor_oe <= tick;
    end

    assign mask_len = cfg_ff[CFG_TPM_BIT] ? TPM_HI : TPM_LO;
    assign ratio    = cfg_ff[CFG_RATIO_BIT] ? RATIO_HI : RATIO_LO;
    assign ext      = cfg_ff[CFG_EXT_BIT] ? EXT_HI : EXT_LO;
    assign lim      = (wd_st_ff == WD_FIRST) ? win_len(mask_len, ratio + ext)
                                             : win_len(mask_len, ratio + 16'h0001);
    assign cnt_inc  = wd_cnt_ff + 16'h0001;
    assign wd_run   = (|watch) && ((watch & en) == watch) && !shut_ff;
    assign in_upd   = (wd_st_ff == WD_FIRST) || (wd_st_ff == WD_UPDATE);
    assign ref_done = armed_ff && ref_q_ff && !watchdog_refresh_in;
    assign expire   = wd_run && in_upd && !ref_done && tick && (cnt_inc == lim);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wd_st_ff  <= WD_IDLE;
            wd_cnt_ff <= 16'h0000;
        end
        else if (!wd_run)
        begin
            wd_st_ff  <= WD_IDLE;
            wd_cnt_ff <= 16'h0000;
        end
        else
        begin
            case (wd_st_ff)
                WD_IDLE:
                begin
                    wd_st_ff  <= WD_FIRST;
                    wd_cnt_ff <= 16'h0000;
                end
                WD_MASK:
                begin
                    if (tick && cnt_inc == mask_len)
                    begin
                        wd_st_ff  <= WD_UPDATE;
                        wd_cnt_ff <= 16'h0000;
                    end
                    else if (tick)
                        wd_cnt_ff <= cnt_inc;
                end
                default:
                begin
                    if (ref_done)
                    begin
                        wd_st_ff  <= WD_MASK;
                        wd_cnt_ff <= 16'h0000;
                    end
                    else if (expire)
                    begin
                        wd_st_ff  <= WD_FIRST;
                        wd_cnt_ff <= 16'h0000;
                    end
                    else if (tick)
                        wd_cnt_ff <= cnt_inc;
                end
            endcase
        end
    end

    // refresh pulse only counts if its rising edge falls outside the mask
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_q_ff <= 1'b0;
            armed_ff <= 1'b0;
            trip_ff  <= 1'b0;
        end
        else
        begin
            ref_q_ff <= watchdog_refresh_in;
            trip_ff  <= expire;
            if (!wd_run || !in_upd || ref_done)
                armed_ff <= 1'b0;
            else if (watchdog_refresh_in && !ref_q_ff)
                armed_ff <= 1'b1;
        end
    end

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_ch
            wds_chan #(
                .SS_CYC   (g == 0 ? SS_BOOST_CYC_P : SS_BUCK_CYC_P),
                .HOLD_CYC (RST_HOLD_CYC_P)
            ) u_ch (
                .ref_clk    (ref_clk),
                .rst_n      (rst_n),
                .en         (en[g]),
                .in_window  (win[g]),
                .rst_pin_i  (rpin[g]),
                .sense_open (sopen[g]),
                .shutdown   (shut_ff),
                .wd_trip    (trip_ff && watch[g]),
                .conv_on    (on[g]),
                .ramp       (ramp[g]),
                .rst_oe     (rst_oe[g])
            );
        end
    endgenerate

    assign boost_channel_reset_n_oe = rst_oe[0];
    assign buck_a_reset_n_oe        = rst_oe[1];
    assign buck_b_reset_n_oe        = rst_oe[2];
    assign boost_output_on          = on[0];
    assign buck_a_output_on         = on[1];
    assign buck_b_output_on         = on[2];
    assign boost_soft_start         = ramp[0];
    assign buck_a_soft_start        = ramp[1];
    assign buck_b_soft_start        = ramp[2];

    // period between sync rises, in reference cycles
    assign srise = sync_pin_i && !sync_q_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_q_ff <= 1'b0;
            per_ff    <= 4'hF;
            locked_ff <= 1'b0;
        end
        else
        begin
            sync_q_ff <= sync_pin_i;
            if (srise)
                per_ff <= 4'h1;
            else if (per_ff != 4'hF)
                per_ff <= per_ff + 4'h1;
            if (cfg_ff[CFG_SYNC_BIT])
                locked_ff <= 1'b0;
            else if (srise)
                locked_ff <= per_ff >= SYNC_MIN_CYC && per_ff <= SYNC_MAX_CYC;
            else if (per_ff > SYNC_MAX_CYC)
                locked_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            forced_fixed_frequency_mode <= 1'b0;
        else
            forced_fixed_frequency_mode <= cfg_ff[CFG_SYNC_BIT] || sync_pin_i || locked_ff;
    end

    // phase accumulator; spread step redrawn once per output period
    assign step    = locked_ff ? NCO_STEP
                               : NCO_LOW + 32'(NCO_UNIT * 32'(lfsr_ff[15:8]));
    assign acc_sum = {1'b0, acc_ff} + {1'b0, step};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_ff      <= 32'h0000_0000;
            lfsr_ff     <= LFSR_SEED;
            sync_pin_o  <= 1'b0;
            sync_pin_oe <= 1'b0;
        end
        else
        begin
            acc_ff      <= acc_sum[31:0];
            sync_pin_o  <= acc_sum[31];
            sync_pin_oe <= cfg_ff[CFG_SYNC_BIT];
            if (acc_sum[32])
                lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[14] ^ lfsr_ff[12] ^ lfsr_ff[3]};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence dis_pulse_s;
        watchdog_tick_capacitor_oe ##1 !watchdog_tick_capacitor_oe;
    endsequence

    trip_resets_a: assert property ((trip_ff && watch[0] && boost_output_on) |=> rst_oe[0])
        else $error("watched channel reset not asserted on expiry");
    idle_off_a: assert property (!wd_run |=> wd_st_ff == WD_IDLE && wd_cnt_ff == 16'h0000)
        else $error("watchdog active while not allowed");
    first_window_a: assert property ((wd_run && wd_st_ff == WD_IDLE) |=> wd_st_ff == WD_FIRST)
        else $error("start did not enter first window");
    mask_ignore_a: assert property ((wd_run && wd_st_ff == WD_MASK && !tick) |=>
        wd_st_ff == WD_MASK && !armed_ff)
        else $error("refresh acted during mask window");
    refresh_restart_a: assert property ((wd_run && ref_done) |=>
        wd_st_ff == WD_MASK && wd_cnt_ff == 16'h0000)
        else $error("refresh did not restart cycle");
    discharge_a: assert property (tick |=> dis_pulse_s)
        else $error("capacitor discharge pulse wrong");
    pg_low_a: assert property (!(|en) |=> input_power_good_n_oe)
        else $error("power good not low in shutdown");
    thermal_off_a: assert property (over_temp |=> !bias_enable ##1 !boost_output_on)
        else $error("thermal shutdown did not stop");
    sync_out_a: assert property (cfg_ff[CFG_SYNC_BIT] |=>
        forced_fixed_frequency_mode && sync_pin_oe)
        else $error("sync output mode not applied");
endmodule // wds_top

// file: test/wds_host.sv
`timescale 1ns/1ns
module wds_host
(
    input  wire logic ref_clk,
    input  wire logic go,
    output logic      refresh
);
    // one-cycle high pulse, so rise and fall both land inside the window
    initial refresh = 1'b0;
    always @(posedge ref_clk)
        refresh <= go && !refresh;
endmodule // wds_host

// file: test/tb_windowed_watchdog_supervisor.sv
`timescale 1ns/1ns
module tb_windowed_watchdog_supervisor;
    import wds_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, cap = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, hready, sh = 1'b1, watchdog_refresh_in, sync_pin_i = 1'b0;
    logic boost_channel_enable = 0, buck_a_channel_enable = 0, buck_b_channel_enable = 0;
    logic boost_in_window = 1, buck_a_in_window = 1, buck_b_in_window = 1;
    logic boost_sense_open = 0, buck_a_sense_open = 0, buck_b_sense_open = 0;
    logic input_supply_ok = 1, over_temp = 0, temp_cooled = 0, watchdog_tick_capacitor_i;
    logic boost_channel_reset_n_i, boost_channel_reset_n_o, boost_channel_reset_n_oe;
    logic buck_a_reset_n_i, buck_a_reset_n_o, buck_a_reset_n_oe;
    logic buck_b_reset_n_i, buck_b_reset_n_o, buck_b_reset_n_oe;
    logic boost_output_on, buck_a_output_on, buck_b_output_on;
    logic boost_soft_start, buck_a_soft_start, buck_b_soft_start;
    logic watchdog_tick_capacitor_o, watchdog_tick_capacitor_oe, bias_enable;
    logic input_power_good_n_o, input_power_good_n_oe, sync_pin_o, sync_pin_oe;
    logic forced_fixed_frequency_mode;
    int bad_count = 0, checks_done = 0, cyc = 0;
    assign hready = hreadyout;
    assign watchdog_tick_capacitor_i = cap;
    // pulled-up reset pins; buck_b pin is shorted high
    assign boost_channel_reset_n_i = !boost_channel_reset_n_oe;
    assign buck_a_reset_n_i = !buck_a_reset_n_oe;
    assign buck_b_reset_n_i = sh | !buck_b_reset_n_oe;
    wds_top #(.RST_HOLD_CYC_P(20), .SS_BOOST_CYC_P(8), .SS_BUCK_CYC_P(12)) i_dut (.*);
    wds_host i_host (.ref_clk(ref_clk), .go(go), .refresh(watchdog_refresh_in));
    always #50 ref_clk = !ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wst(input logic [1:0] e);
        ahb(1'b0, STAT_ADDR, 32'h0);
        chk({30'h0, r[11:10]}, {30'h0, e});
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            cap <= 1'b1;
            @(posedge ref_clk) cap <= 1'b0;
            @(negedge ref_clk) chk(watchdog_tick_capacitor_oe, 1);
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task automatic refr();
        go <= 1'b1;
        @(posedge ref_clk) go <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_regs();
        rd(CFG_ADDR, 32'h0000_0000);
        rd(32'h0000_000C, 32'h0000_0000);
        ahb(1'b1, CFG_ADDR, 32'hFFFF_FFFF);
        rd(CFG_ADDR, 32'h0000_007F);
        chk({30'h0, sync_pin_oe, forced_fixed_frequency_mode}, 32'h0000_0003);
        ahb(1'b1, CFG_ADDR, 32'h0000_0000);
        chk(input_power_good_n_oe, 1);
        chk({27'h0, boost_channel_reset_n_o, buck_a_reset_n_o, buck_b_reset_n_o,
             watchdog_tick_capacitor_o, input_power_good_n_o}, 32'h0);
    endtask
    task automatic t_chan();
        {boost_channel_enable, buck_a_channel_enable, buck_b_channel_enable} <= 3'b111;
        repeat (6) @(posedge ref_clk);
        chk(boost_soft_start, 1);
        chk(buck_b_output_on, 0);
        chk(buck_b_soft_start, 0);
        repeat (4) @(posedge ref_clk);
        chk(boost_soft_start, 0);
        chk(buck_a_soft_start, 1);
        repeat (22) @(posedge ref_clk);
        chk(boost_channel_reset_n_oe, 0);
        chk(buck_a_reset_n_oe, 1);
        repeat (4) @(posedge ref_clk);
        chk(buck_a_reset_n_oe, 0);
        boost_in_window <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(boost_channel_reset_n_oe, 1);
        boost_in_window <= 1'b1;
        repeat (25) @(posedge ref_clk);
        chk(boost_channel_reset_n_oe, 0);
    endtask
    task automatic t_wd();
        ahb(1'b1, CFG_ADDR, 32'h0000_0003);
        wst(2'h1);
        tick(16);
        rd(TICK_ADDR, 32'h0000_0010);
        refr();
        wst(2'h2);
        rd(TICK_ADDR, 32'h0000_0000);
        tick(4);
        refr();
        wst(2'h2);
        rd(TICK_ADDR, 32'h0000_0004);
        tick(12);
        wst(2'h3);
        refr();
        tick(159);
        wst(2'h3);
        chk(boost_channel_reset_n_oe, 0);
        tick(1);
        repeat (3) @(posedge ref_clk);
        chk(boost_channel_reset_n_oe, 1);
        chk(buck_a_reset_n_oe, 1);
    endtask
    task automatic t_misc();
        buck_a_channel_enable <= 1'b0;
        tick(1);
        wst(2'h0);
        rd(TICK_ADDR, 32'h0000_0000);
        buck_a_channel_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wst(2'h1);
        tick(1151);
        rd(TICK_ADDR, 32'h0000_047F);
        chk(boost_channel_reset_n_oe, 0);
        tick(1);
        repeat (3) @(posedge ref_clk);
        chk(boost_channel_reset_n_oe, 1);
        chk(input_power_good_n_oe, 0);
        input_supply_ok <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(input_power_good_n_oe, 1);
        input_supply_ok <= 1'b1;
        sync_pin_i <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(forced_fixed_frequency_mode, 1);
        over_temp <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(bias_enable, 0);
        chk(boost_output_on, 0);
        over_temp <= 1'b0;
        temp_cooled <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(bias_enable, 1);
        boost_sense_open <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(boost_output_on, 0);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_chan();
        t_wd();
        t_misc();
        report_and_stop();
    end
endmodule // tb_windowed_watchdog_supervisor
